// [rtl/port_stats_pkg.sv]
package port_stats_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_PORTS    = 3;
    localparam int CNT_PER_PORT = 32;
    localparam int NUM_CELLS    = NUM_PORTS * CNT_PER_PORT;
    localparam int CNT_W        = 30;
    localparam int INC_W        = 11;
    localparam int DROP_W       = 16;
    localparam int NUM_DROPS    = 2 * NUM_PORTS;
    localparam int OFS_W        = 10;
    localparam int COLL_W       = 5;

    // ****************************************
    // Indirect map and control layout
    // ****************************************
    localparam logic [OFS_W-1:0] PORT_MAP_END = 10'h060;
    localparam logic [OFS_W-1:0] DROP_TX_BASE = 10'h100;
    localparam logic [OFS_W-1:0] DROP_RX_BASE = 10'h103;
    localparam logic [OFS_W-1:0] DROP_END     = 10'h105;
    localparam int               OVF_BIT      = 31;
    localparam int               VALID_BIT    = 30;
    localparam int               CMD_LSB      = 10;
    localparam logic [2:0]       CMD_READ_MIB = 3'h7;
    localparam logic [31:0]      UNMAPPED_RD  = 32'h4000_0000;

    // ****************************************
    // Frame length limits in octets
    // ****************************************
    localparam logic [INC_W-1:0] LEN_MIN     = 11'h040;
    localparam logic [INC_W-1:0] LEN_127     = 11'h07F;
    localparam logic [INC_W-1:0] LEN_255     = 11'h0FF;
    localparam logic [INC_W-1:0] LEN_511     = 11'h1FF;
    localparam logic [INC_W-1:0] LEN_1023    = 11'h3FF;
    localparam logic [INC_W-1:0] LEN_STD_MAX = 11'h5F2;
    localparam logic [INC_W-1:0] LEN_ABS_MAX = 11'h7D0;

    // ****************************************
    // Counter offsets within one port
    // ****************************************
    localparam logic [4:0] OFS_RX_LO_OCT   = 5'h00;
    localparam logic [4:0] OFS_RX_HI_OCT   = 5'h01;
    localparam logic [4:0] OFS_RX_SHORT_OK = 5'h02;
    localparam logic [4:0] OFS_RX_SHORT_BD = 5'h03;
    localparam logic [4:0] OFS_RX_LONG_OK  = 5'h04;
    localparam logic [4:0] OFS_RX_LONG_BD  = 5'h05;
    localparam logic [4:0] OFS_RX_BAD_SYM  = 5'h06;
    localparam logic [4:0] OFS_RX_CKSUM    = 5'h07;
    localparam logic [4:0] OFS_RX_PARTIAL  = 5'h08;
    localparam logic [4:0] OFS_RX_MAC_CTL  = 5'h09;
    localparam logic [4:0] OFS_RX_PAUSE    = 5'h0A;
    localparam logic [4:0] OFS_RX_BCAST    = 5'h0B;
    localparam logic [4:0] OFS_RX_MCAST    = 5'h0C;
    localparam logic [4:0] OFS_RX_UCAST    = 5'h0D;
    localparam logic [4:0] OFS_RX_LEN_MIN  = 5'h0E;
    localparam logic [4:0] OFS_RX_LEN_BIN2 = 5'h0F;
    localparam logic [4:0] OFS_RX_LEN_BIN3 = 5'h10;
    localparam logic [4:0] OFS_RX_LEN_BIN4 = 5'h11;
    localparam logic [4:0] OFS_RX_LEN_BIN5 = 5'h12;
    localparam logic [4:0] OFS_RX_LEN_TOP  = 5'h13;
    localparam logic [4:0] OFS_TX_LO_OCT   = 5'h14;
    localparam logic [4:0] OFS_TX_HI_OCT   = 5'h15;
    localparam logic [4:0] OFS_TX_LATE_COL = 5'h16;
    localparam logic [4:0] OFS_TX_PAUSE    = 5'h17;
    localparam logic [4:0] OFS_TX_BCAST    = 5'h18;
    localparam logic [4:0] OFS_TX_MCAST    = 5'h19;
    localparam logic [4:0] OFS_TX_UCAST    = 5'h1A;
    localparam logic [4:0] OFS_TX_DEFERRED = 5'h1B;
    localparam logic [4:0] OFS_TX_ALL_COL  = 5'h1C;
    localparam logic [4:0] OFS_TX_ABANDON  = 5'h1D;
    localparam logic [4:0] OFS_TX_ONE_RTY  = 5'h1E;
    localparam logic [4:0] OFS_TX_MULTI    = 5'h1F;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic             done;
        logic [INC_W-1:0] len;
        logic             crcOk;
        logic             partial;
        logic             symErr;
        logic             highPrio;
        logic             bcast;
        logic             mcast;
        logic             macCtrl;
        logic             pauseMatch;
    } rx_frame_t;

    typedef struct packed {
        logic              done;
        logic [INC_W-1:0]  len;
        logic              ok;
        logic              highPrio;
        logic              bcast;
        logic              mcast;
        logic              pause;
        logic              deferred;
        logic              lateColl;
        logic              abandoned;
        logic [COLL_W-1:0] collisions;
    } tx_frame_t;

    typedef struct packed {
        logic        write;
        logic [15:0] value;
    } ctrl_req_t;

    typedef logic [CNT_PER_PORT-1:0][INC_W-1:0] inc_vec_t;

endpackage : port_stats_pkg

// [rtl/port_stat_cell.sv]
`timescale 1ns/1ps
module port_stat_cell
    import port_stats_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int IW = INC_W
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic [IW-1:0] inc,
    input  wire logic          clear,
    output logic      [CW-1:0] count,
    output logic               overflow
);
    localparam int SW = CW + 1;

    logic [CW-1:0] count_q;
    logic          overflow_q;
    logic [SW-1:0] sum;

    // Clear then add: an event in the read cycle is kept
    always_comb begin
        sum = SW'(clear ? '0 : count_q) + SW'(inc);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            count_q <= '0;
        end else begin
            count_q <= sum[CW-1:0];
        end
    end

    // Sticky carry out, dropped only by a read
    always_ff @(posedge clock) begin
        if (!nrst) begin
            overflow_q <= 1'b0;
        end else if (clear) begin
            overflow_q <= sum[CW];
        end else begin
            overflow_q <= overflow_q | sum[CW];
        end
    end

    assign count    = count_q;
    assign overflow = overflow_q;

    chk_read_clear: assert property (@(posedge clock) disable iff (!nrst) // [RULE_02]
        clear |=> count_q == CW'($past(inc)))
        else $error("read clear did not restart the count");

    chk_ovf_sticky: assert property (@(posedge clock) disable iff (!nrst) // [RULE_26]
        overflow_q && !clear |=> overflow_q [*2] or ##1 $past(clear, 1))
        else $error("overflow flag fell without a read");

    chk_ovf_set: assert property (@(posedge clock) disable iff (!nrst) // [RULE_26]
        !clear && (SW'(count_q) + SW'(inc)) > SW'({CW{1'b1}}) |=> overflow_q)
        else $error("wrap did not raise overflow");

endmodule : port_stat_cell

// [rtl/port_statistics_counters.sv]
`timescale 1ns/1ps
// Functional notes
// RULE_01: Word: overflow, valid, 30-bit count
// RULE_02: Reading a port counter clears it
// RULE_03: Ports at 0x00, 0x20, 0x40
// RULE_04: Low data 15:0, high data 31:16
// RULE_05: Offsets 0,1 count rx octets by priority
// RULE_06: Short frames with good checksum
// RULE_07: Short frames with any error
// RULE_08: Long good frames, limit at most 2000
// RULE_09: Long frames with any error
// RULE_10: Legal length with bad symbol
// RULE_11: Legal length, whole bytes, bad checksum
// RULE_12: Legal length, partial byte, bad checksum
// RULE_13: MAC control and qualified pause frames
// RULE_14: Good broadcast, multicast, unicast received
// RULE_15: Six received length bins
// RULE_16: Tx octets by priority, pause included
// RULE_17: Late collisions past 512 bit-times
// RULE_18: Pause frames sent
// RULE_19: Good broadcast, multicast, unicast sent
// RULE_20: Deferral and collision counts, in order
// RULE_21: Drop counts 16 bits, no flags
// RULE_22: Drops at 0x100-0x102 tx, 0x103-0x105 rx
// RULE_23: Host writes command, reads high then low
// RULE_24: Host rereads high while valid is zero
// RULE_25: Drop counters keep value on read
// RULE_26: Overflow sticks until next read
module port_statistics_counters
    import port_stats_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            nrst,
    input  wire rx_frame_t [NUM_PORTS-1:0]       rxFrame,
    input  wire tx_frame_t [NUM_PORTS-1:0]       txFrame,
    input  wire logic      [INC_W-1:0]           maxFrameLen,
    input  wire logic      [NUM_PORTS-1:0]       txDrop,
    input  wire logic      [NUM_PORTS-1:0]       rxDrop,
    input  wire ctrl_req_t                       ctrlReq,
    output logic           [15:0]                indirectDataLow,
    output logic           [15:0]                indirectDataHigh,
    output logic                                 readBusy
);

    // ****************************************
    // Types and signals
    // ****************************************
    typedef enum logic [0:0] {
        RD_IDLE    = 1'b0,
        RD_CAPTURE = 1'b1
    } rd_state_t;

    rd_state_t                 state_q;
    rd_state_t                 state_d;
    logic [OFS_W-1:0]          selOfs_q;
    logic [15:0]               dataLow_q;
    logic [15:0]               dataHigh_q;
    logic [15:0]               dataLow_d;
    logic [15:0]               dataHigh_d;
    logic                      accept;
    logic                      capture;
    logic [31:0]               selWord;
    logic [INC_W-1:0]          maxEff;
    inc_vec_t [NUM_PORTS-1:0]  incs;
    logic [CNT_W-1:0]          cellCnt [NUM_CELLS];
    logic                      cellOvf [NUM_CELLS];
    logic [DROP_W-1:0]         dropCnt_q [NUM_DROPS];
    logic [NUM_DROPS-1:0]      dropEvent;

    // ****************************************
    // Event classification
    // ****************************************
    // Limit never exceeds the largest supported frame
    always_comb begin
        maxEff = (maxFrameLen > LEN_ABS_MAX) ? LEN_ABS_MAX : maxFrameLen; // [RULE_08]
    end

    function automatic inc_vec_t classify(
        input rx_frame_t        r,
        input tx_frame_t        t,
        input logic [INC_W-1:0] maxLen
    );
        inc_vec_t v;
        logic     shortF;
        logic     longF;
        logic     legal;
        logic     bad;
        logic     good;
        logic     txOk;
        v      = '0;
        shortF = r.len < LEN_MIN;
        longF  = r.len > maxLen;
        legal  = !shortF && !longF;
        bad    = !r.crcOk || r.symErr || r.partial;
        good   = r.done && legal && !bad;
        txOk   = t.done && t.ok;
        // Octets of errored frames count as well
        v[OFS_RX_LO_OCT] = (r.done && !r.highPrio) ? r.len : '0; // [RULE_05]
        v[OFS_RX_HI_OCT] = (r.done && r.highPrio) ? r.len : '0; // [RULE_05]
        v[OFS_RX_SHORT_OK] = INC_W'(r.done && shortF && !bad); // [RULE_06]
        v[OFS_RX_SHORT_BD] = INC_W'(r.done && shortF && bad); // [RULE_07]
        v[OFS_RX_LONG_OK] = INC_W'(r.done && longF && !bad); // [RULE_08]
        v[OFS_RX_LONG_BD] = INC_W'(r.done && longF && bad); // [RULE_09]
        v[OFS_RX_BAD_SYM] = INC_W'(r.done && legal && r.symErr); // [RULE_10]
        v[OFS_RX_CKSUM] = INC_W'(r.done && legal && !r.partial && !r.crcOk); // [RULE_11]
        v[OFS_RX_PARTIAL] = INC_W'(r.done && legal && r.partial && !r.crcOk); // [RULE_12]
        v[OFS_RX_MAC_CTL] = INC_W'(r.done && r.macCtrl); // [RULE_13]
        v[OFS_RX_PAUSE] = INC_W'(r.done && r.macCtrl && r.pauseMatch // [RULE_13]
                                 && r.crcOk && !shortF);
        v[OFS_RX_BCAST] = INC_W'(good && r.bcast); // [RULE_14]
        v[OFS_RX_MCAST] = INC_W'(good && r.mcast && !r.bcast && !r.macCtrl); // [RULE_14]
        v[OFS_RX_UCAST] = INC_W'(good && !r.mcast && !r.bcast); // [RULE_14]
        v[OFS_RX_LEN_MIN] = INC_W'(r.done && r.len == LEN_MIN); // [RULE_15]
        v[OFS_RX_LEN_BIN2] = INC_W'(r.done && r.len > LEN_MIN && r.len <= LEN_127); // [RULE_15]
        v[OFS_RX_LEN_BIN3] = INC_W'(r.done && r.len > LEN_127 && r.len <= LEN_255); // [RULE_15]
        v[OFS_RX_LEN_BIN4] = INC_W'(r.done && r.len > LEN_255 && r.len <= LEN_511); // [RULE_15]
        v[OFS_RX_LEN_BIN5] = INC_W'(r.done && r.len > LEN_511 && r.len <= LEN_1023); // [RULE_15]
        v[OFS_RX_LEN_TOP] = INC_W'(r.done && r.len > LEN_1023 && !longF); // [RULE_15]
        // Pause frames sent are part of the octet totals
        v[OFS_TX_LO_OCT] = (txOk && !t.highPrio) ? t.len : '0; // [RULE_16]
        v[OFS_TX_HI_OCT] = (txOk && t.highPrio) ? t.len : '0; // [RULE_16]
        v[OFS_TX_LATE_COL] = INC_W'(t.done && t.lateColl); // [RULE_17]
        v[OFS_TX_PAUSE] = INC_W'(txOk && t.pause); // [RULE_18]
        v[OFS_TX_BCAST] = INC_W'(txOk && t.bcast); // [RULE_19]
        v[OFS_TX_MCAST] = INC_W'(txOk && t.mcast && !t.bcast); // [RULE_19]
        v[OFS_TX_UCAST] = INC_W'(txOk && !t.mcast && !t.bcast); // [RULE_19]
        v[OFS_TX_DEFERRED] = INC_W'(t.done && t.deferred); // [RULE_20]
        v[OFS_TX_ALL_COL] = t.done ? INC_W'(t.collisions) : '0; // [RULE_20]
        v[OFS_TX_ABANDON] = INC_W'(t.done && t.abandoned); // [RULE_20]
        v[OFS_TX_ONE_RTY] = INC_W'(txOk && t.collisions == COLL_W'(1)); // [RULE_20]
        v[OFS_TX_MULTI] = INC_W'(txOk && t.collisions > COLL_W'(1)); // [RULE_20]
        return v;
    endfunction : classify

    // ****************************************
    // Per-port counter bank
    // ****************************************
    genvar gp;
    genvar gc;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            always_comb begin
                incs[gp] = classify(rxFrame[gp], txFrame[gp], maxEff);
            end
            for (gc = 0; gc < CNT_PER_PORT; gc++) begin : g_cnt
                localparam int IDX = gp * CNT_PER_PORT + gc;
                logic clr;
                // Port bank base is port index times 32
                always_comb begin
                    clr = capture && selOfs_q == OFS_W'(IDX); // [RULE_02] [RULE_03]
                end
                port_stat_cell #(
                    .CW (CNT_W),
                    .IW (INC_W)
                ) u_cell (
                    .clock    (clock),
                    .nrst     (nrst),
                    .inc      (incs[gp][gc]),
                    .clear    (clr),
                    .count    (cellCnt[IDX]),
                    .overflow (cellOvf[IDX])
                );
            end
        end
    endgenerate

    // ****************************************
    // Shared dropped-frame counters
    // ****************************************
    always_comb begin
        dropEvent = {rxDrop, txDrop}; // [RULE_22]
    end

    genvar gd;
    generate
        for (gd = 0; gd < NUM_DROPS; gd++) begin : g_drop
            // Free-running wrap; software tracks rollover itself
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    dropCnt_q[gd] <= '0;
                end else if (dropEvent[gd]) begin
                    dropCnt_q[gd] <= dropCnt_q[gd] + DROP_W'(1); // [RULE_21] [RULE_25]
                end
            end

            chk_drop_no_clear: assert property (@(posedge clock) disable iff (!nrst) // [RULE_25]
                ##1 dropCnt_q[gd] == $past(dropCnt_q[gd]) + DROP_W'($past(dropEvent[gd])))
                else $error("drop counter changed other than by an event");
        end
    endgenerate

    // ****************************************
    // Indirect read sequencer
    // ****************************************
    always_comb begin
        accept  = ctrlReq.write
                  && ctrlReq.value[CMD_LSB +: 3] == CMD_READ_MIB; // [RULE_23]
        capture = state_q == RD_CAPTURE;
    end

    // Word seen by the host for the latched offset
    always_comb begin
        if (selOfs_q < PORT_MAP_END) begin
            selWord = {cellOvf[selOfs_q[6:0]], 1'b1, cellCnt[selOfs_q[6:0]]}; // [RULE_01]
        end else if (selOfs_q >= DROP_TX_BASE && selOfs_q <= DROP_END) begin
            selWord = {16'h0000, dropCnt_q[3'(selOfs_q - DROP_TX_BASE)]}; // [RULE_21]
        end else begin
            selWord = UNMAPPED_RD;
        end
    end

    always_comb begin
        case (state_q)
            RD_IDLE: begin
                state_d = accept ? RD_CAPTURE : RD_IDLE;
            end
            RD_CAPTURE: begin
                state_d = accept ? RD_CAPTURE : RD_IDLE;
            end
            default: begin
                state_d = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= RD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            selOfs_q <= '0;
        end else if (accept) begin
            selOfs_q <= ctrlReq.value[OFS_W-1:0];
        end
    end

    // Valid stays low while a newer request is still in flight
    always_comb begin
        dataLow_d  = capture ? selWord[15:0] : dataLow_q; // [RULE_04]
        dataHigh_d = capture ? selWord[31:16] : dataHigh_q; // [RULE_04]
        if (accept) begin
            dataHigh_d[VALID_BIT-16] = 1'b0; // [RULE_24]
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            dataLow_q  <= '0;
            dataHigh_q <= '0;
        end else begin
            dataLow_q  <= dataLow_d;
            dataHigh_q <= dataHigh_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            readBusy <= 1'b0;
        end else begin
            readBusy <= state_d == RD_CAPTURE;
        end
    end

    assign indirectDataLow  = dataLow_q;
    assign indirectDataHigh = dataHigh_q;

    // ****************************************
    // Checks
    // ****************************************
    chk_accept_busy: assert property (@(posedge clock) disable iff (!nrst) // [RULE_23]
        accept |=> readBusy && state_q == RD_CAPTURE)
        else $error("accepted request did not start a capture");

    chk_valid_drop: assert property (@(posedge clock) disable iff (!nrst) // [RULE_24]
        accept |=> !indirectDataHigh[VALID_BIT-16])
        else $error("valid flag not dropped on a new request");

    chk_word_split: assert property (@(posedge clock) disable iff (!nrst) // [RULE_04]
        capture && !accept |=> {indirectDataHigh, indirectDataLow} == $past(selWord))
        else $error("snapshot not split into high and low words");

    chk_valid_rise: assert property (@(posedge clock) disable iff (!nrst) // [RULE_01]
        accept ##1 !accept && selOfs_q < PORT_MAP_END
        |=> indirectDataHigh[VALID_BIT-16] && !readBusy)
        else $error("port counter read did not come back valid");

    chk_drop_format: assert property (@(posedge clock) disable iff (!nrst) // [RULE_21]
        capture && !accept && selOfs_q >= DROP_TX_BASE && selOfs_q <= DROP_END
        |=> indirectDataHigh == 16'h0000)
        else $error("drop counter word carries flags");

    chk_port_clear: assert property (@(posedge clock) disable iff (!nrst) // [RULE_02]
        capture && selOfs_q == OFS_W'(OFS_RX_LEN_MIN) && incs[0][OFS_RX_LEN_MIN] == '0
        |=> cellCnt[OFS_RX_LEN_MIN] == '0 && !cellOvf[OFS_RX_LEN_MIN])
        else $error("port counter not cleared by its read");

    chk_len_min_bin: assert property (@(posedge clock) disable iff (!nrst) // [RULE_15]
        rxFrame[0].done && rxFrame[0].len == LEN_MIN
        |-> incs[0][OFS_RX_LEN_MIN] == INC_W'(1) && incs[0][OFS_RX_LEN_BIN2] == '0)
        else $error("minimum length frame landed in the wrong bin");

    chk_long_limit: assert property (@(posedge clock) disable iff (!nrst) // [RULE_08]
        rxFrame[1].done && rxFrame[1].len > LEN_ABS_MAX && rxFrame[1].crcOk
        && !rxFrame[1].symErr && !rxFrame[1].partial
        |-> incs[1][OFS_RX_LONG_OK] == INC_W'(1))
        else $error("frame over the absolute limit not counted as long");

    chk_port3_base: assert property (@(posedge clock) disable iff (!nrst) // [RULE_03]
        capture && !accept && selOfs_q == 10'h040
        |=> indirectDataLow == $past(cellCnt[2 * CNT_PER_PORT][15:0]))
        else $error("port three bank not at its base offset");

endmodule : port_statistics_counters

// [testbench/host_model.sv]
`timescale 1ns/1ps
module host_model
    import port_stats_pkg::*;
(
    input  wire logic        clock,
    input  wire logic [15:0] indirectDataLow,
    input  wire logic [15:0] indirectDataHigh,
    input  wire logic        readBusy,
    output ctrl_req_t        ctrlReq
);
    initial ctrlReq = '0;

    task automatic read_word(input logic [OFS_W-1:0] ofs, output logic [31:0] word,
                             output logic busy);
        logic [15:0] high;
        int          tries;
        @(negedge clock);
        ctrlReq = '{write: 1'b1, value: {3'b000, CMD_READ_MIB, ofs}};
        @(negedge clock);
        ctrlReq.write = 1'b0;
        busy = readBusy;
        tries = 0;
        do begin
            @(negedge clock);
            high = indirectDataHigh;
            tries++;
        end while ((readBusy || (ofs < PORT_MAP_END && !high[VALID_BIT-16])) && tries < 8);
        word = {high, indirectDataLow};
    endtask : read_word
endmodule : host_model

// [testbench/port_statistics_counters_bench.sv]
`timescale 1ns/1ps
module port_statistics_counters_bench;
    import port_stats_pkg::*;
    logic                      clock;
    logic                      nrst;
    rx_frame_t [NUM_PORTS-1:0] rxFrame;
    tx_frame_t [NUM_PORTS-1:0] txFrame;
    logic      [INC_W-1:0]     maxFrameLen;
    logic      [NUM_PORTS-1:0] txDrop;
    logic      [NUM_PORTS-1:0] rxDrop;
    ctrl_req_t                 ctrlReq;
    logic      [15:0]          indirectDataLow;
    logic      [15:0]          indirectDataHigh;
    logic                      readBusy;
    int                        error_cnt = 0;
    int                        total_checks = 0;
    int                        cycles = 0;
    logic      [29:0]          expCnt [NUM_PORTS][CNT_PER_PORT];
    logic      [15:0]          expDrop [NUM_DROPS];
    logic      [INC_W-1:0]     lens [10] = '{63, 64, 65, 127, 128, 1023, 1024, 1522, 1523, 2000};

    port_statistics_counters dut (.clock(clock), .nrst(nrst), .rxFrame(rxFrame),
        .txFrame(txFrame), .maxFrameLen(maxFrameLen), .txDrop(txDrop), .rxDrop(rxDrop),
        .ctrlReq(ctrlReq), .indirectDataLow(indirectDataLow),
        .indirectDataHigh(indirectDataHigh), .readBusy(readBusy));
    host_model host (.clock(clock), .indirectDataLow(indirectDataLow),
        .indirectDataHigh(indirectDataHigh), .readBusy(readBusy), .ctrlReq(ctrlReq));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ****************************************
    // Expected increments
    // ****************************************
    function automatic logic [29:0] exp_inc(rx_frame_t r, tx_frame_t t, int o);
        logic bad;
        logic lng;
        logic legal;
        bad = !r.crcOk || r.symErr || r.partial;
        // Configured limit never goes past the largest supported frame
        lng = r.len > ((maxFrameLen > LEN_ABS_MAX) ? LEN_ABS_MAX : maxFrameLen);
        legal = r.len >= LEN_MIN && !lng;
        if ((o < 20 && !r.done) || (o >= 20 && !t.done)) return '0;
        case (o)
            0: return r.highPrio ? '0 : 30'(r.len);
            1: return r.highPrio ? 30'(r.len) : '0;
            2: return 30'(r.len < LEN_MIN && !bad);
            3: return 30'(r.len < LEN_MIN && bad);
            4: return 30'(lng && !bad);
            5: return 30'(lng && bad);
            6: return 30'(r.symErr && legal);
            7: return 30'(legal && !r.partial && !r.crcOk);
            8: return 30'(legal && r.partial && !r.crcOk);
            9: return 30'(r.macCtrl);
            10: return 30'(r.macCtrl && r.pauseMatch && r.crcOk && r.len >= LEN_MIN);
            11: return 30'(r.bcast && legal && !bad);
            12: return 30'(r.mcast && !r.macCtrl && legal && !bad);
            13: return 30'(!r.bcast && !r.mcast && legal && !bad);
            14: return 30'(r.len == LEN_MIN);
            15: return 30'(r.len > LEN_MIN && r.len <= LEN_127);
            16: return 30'(r.len > LEN_127 && r.len <= LEN_255);
            17: return 30'(r.len > LEN_255 && r.len <= LEN_511);
            18: return 30'(r.len > LEN_511 && r.len <= LEN_1023);
            19: return 30'(r.len > LEN_1023 && !lng);
            20: return (t.ok && !t.highPrio) ? 30'(t.len) : '0;
            21: return (t.ok && t.highPrio) ? 30'(t.len) : '0;
            22: return 30'(t.lateColl);
            23: return 30'(t.ok && t.pause);
            24: return 30'(t.ok && t.bcast);
            25: return 30'(t.ok && t.mcast);
            26: return 30'(t.ok && !t.bcast && !t.mcast);
            27: return 30'(t.deferred);
            28: return 30'(t.collisions);
            29: return 30'(t.abandoned);
            30: return 30'(t.ok && t.collisions == 1);
            31: return 30'(t.ok && t.collisions > 1);
            default: return '0;
        endcase
    endfunction : exp_inc

    task automatic traffic(input int n);
        rx_frame_t r;
        tx_frame_t t;
        repeat (n) begin
            @(negedge clock);
            for (int p = 0; p < NUM_PORTS; p++) begin
                r = rx_frame_t'(20'($urandom));
                r.symErr &= r.partial;
                r.partial &= r.highPrio;
                r.mcast &= !r.bcast;
                r.macCtrl &= r.mcast;
                if (r.len[10:9] == 2'b00) r.len = lens[$urandom_range(0, 9)];
                t = tx_frame_t'(25'($urandom));
                t.mcast &= !t.bcast;
                t.collisions = 5'(t.collisions[1:0]);
                rxFrame[p] = r;
                txFrame[p] = t;
                txDrop[p] = 1'($urandom_range(0, 1));
                rxDrop[p] = 1'($urandom_range(0, 1));
                expDrop[p] += 16'(txDrop[p]);
                expDrop[p+NUM_PORTS] += 16'(rxDrop[p]);
                for (int o = 0; o < CNT_PER_PORT; o++) expCnt[p][o] += exp_inc(r, t, o);
            end
        end
        @(negedge clock);
        rxFrame = '0;
        txFrame = '0;
        txDrop = '0;
        rxDrop = '0;
    endtask : traffic

    task automatic read_check(input logic [OFS_W-1:0] ofs, input logic [31:0] exp);
        logic [31:0] got;
        logic        busy;
        host.read_word(ofs, got, busy);
        total_checks++;
        if (busy !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t ofs=%h busy=%h exp=%h", $time, ofs, busy, 1'b1);
        end
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t ofs=%h got=%h exp=%h", $time, ofs, got, exp);
        end
    endtask : read_check

    initial begin
        void'($urandom(32'h308B_4AA3));
        nrst = 1'b0;
        rxFrame = '0;
        txFrame = '0;
        txDrop = '0;
        rxDrop = '0;
        maxFrameLen = LEN_STD_MAX;
        expCnt = '{default: '{default: '0}};
        expDrop = '{default: '0};
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        read_check(10'h00E, 32'h4000_0000);
        for (int k = 0; k < 2; k++) begin
            maxFrameLen = k ? 11'h7FF : LEN_STD_MAX;
            traffic(300);
            if (k) maxFrameLen = LEN_ABS_MAX;
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int o = 0; o < CNT_PER_PORT; o++) begin
                    read_check(10'(p * 32 + o), {2'b01, expCnt[p][o]});
                    expCnt[p][o] = '0;
                end
            end
            read_check(10'h02E, 32'h4000_0000);
            for (int i = 0; i < NUM_DROPS; i++) begin
                read_check(DROP_TX_BASE + 10'(i), {16'h0000, expDrop[i]});
                read_check(DROP_TX_BASE + 10'(i), {16'h0000, expDrop[i]});
            end
        end
        read_check(PORT_MAP_END, UNMAPPED_RD);
        give_verdict();
    end
endmodule : port_statistics_counters_bench
